// ### hw/tec_pin_sync.sv
`timescale 1ns/1ps
module tec_pin_sync
  import tec_pkg::*;
#(
  parameter int unsigned W = 3
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } tec_sync_s;

  tec_sync_s r;
  tec_sync_s next_r;

  // s1 feeds only s2; a change is taken once s2 and s3 agree
  always_comb begin
    next_r = r;
    next_r.s1 = din;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < W; i++) begin
      next_r.rise[i] = 1'b0;
      next_r.fall[i] = 1'b0;
      if (r.s2[i] == r.s3[i] && r.s3[i] != r.filt[i]) begin
        next_r.filt[i] = r.s3[i];
        next_r.rise[i] = r.s3[i];
        next_r.fall[i] = ~r.s3[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign level = r.filt;
  assign rise = r.rise;
  assign fall = r.fall;
endmodule : tec_pin_sync

// ### hw/tec_pkg.sv
package tec_pkg;
  localparam int unsigned TEC_ADDR_W = 5;
  localparam int unsigned TEC_CNT_W = 16;

  // register byte offsets, one aligned word each
  localparam logic [4:0] TEC_OFF_A_LO = 5'h00;
  localparam logic [4:0] TEC_OFF_A_HI = 5'h04;
  localparam logic [4:0] TEC_OFF_B_LO = 5'h08;
  localparam logic [4:0] TEC_OFF_B_HI = 5'h0C;
  localparam logic [4:0] TEC_OFF_CTRL = 5'h10;
  localparam logic [4:0] TEC_OFF_CONV = 5'h14;
  localparam logic [4:0] TEC_OFF_STAT = 5'h18;

  // counter_control_reg fields
  localparam int unsigned TEC_CTRL_MODE_LSB = 5;
  localparam int unsigned TEC_CTRL_RUN = 4;
  localparam int unsigned TEC_CTRL_EDGE = 3;
  localparam logic [7:0] TEC_CTRL_MASK = 8'h78;
  localparam logic [7:0] TEC_CTRL_RST = 8'h08;

  // converter_control_reg fields
  localparam int unsigned TEC_CONV_BSEL = 6;
  localparam int unsigned TEC_CONV_EN = 1;
  localparam int unsigned TEC_CONV_OVSEL = 0;
  localparam logic [7:0] TEC_CONV_RST = 8'h00;

  // status register: request flag, write one to clear
  localparam int unsigned TEC_STAT_FLAG = 0;

  // two-bit operating mode codes
  localparam logic [1:0] TEC_MODE_NONE = 2'h0;
  localparam logic [1:0] TEC_MODE_EVENT = 2'h1;
  localparam logic [1:0] TEC_MODE_TIMER = 2'h2;
  localparam logic [1:0] TEC_MODE_PULSE = 2'h3;

  localparam logic [15:0] TEC_CNT_RST = 16'h0000;
  localparam logic [1:0] TEC_RESP_OKAY = 2'h0;
  localparam logic [1:0] TEC_RESP_SLVERR = 2'h2;

  typedef enum {
    TEC_SEL_A_LO, TEC_SEL_A_HI, TEC_SEL_B_LO, TEC_SEL_B_HI,
    TEC_SEL_CTRL, TEC_SEL_CONV, TEC_SEL_STAT, TEC_SEL_NONE
  } tec_sel_e;
endpackage : tec_pkg

// ### hw/tec_timer.sv
// Function
// [R1] converter off: one 16-bit counter, B preloads
// [R2] preload low write buffered, high write loads
// [R3] counter high read latches low byte
// [R4] preload write also loads stopped counter
// [R5] high byte read holds off counting
// [R6] mode field picks event, timer, pulse width
// [R7] count to FFFF, reload and raise flag
// [R8] event edge: 0 rising, 1 falling
// [R9] pulse width: start edge, stop edge, clear run
// [R10] single pulse measured, overflow reloads too
// [R11] count only while run set
// [R12] converter on: two independent 16-bit counters
// [R13] timer B clock: oscillator or reference
// [R14] overflow source select picks A or B
// [R15] selected overflow: flag, stop, clear run
// [R16] counter bytes locked while converter runs
// [R17] converter: low write buffered, high loads
// [R18] converter: high read latches low byte
// [R19] software writes low first, reads high first
// [R20] converter never reloads; B keeps result
// [R21] software loads counters before enabling
// [R22] software sets timer mode in converter
`timescale 1ns/1ps
module tec_timer
  import tec_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [TEC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [TEC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic measure_input_pin,
  input wire logic rf_osc_out,
  input wire logic low_speed_ref_osc,
  output logic rc_timer_request_flag
);
  localparam logic [TEC_CNT_W-1:0] CNT_MAX = '1;

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_got;
    logic [TEC_ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [TEC_CNT_W-1:0] cnt_a;
    logic [TEC_CNT_W-1:0] cnt_b;
    logic [7:0] lo_buf;
    logic [1:0] mode;
    logic run;
    logic edge_pol;
    logic bsel;
    logic conv;
    logic ovsel;
    logic flag;
    logic pw_active;
  } tec_state_s;

  tec_state_s r;
  tec_state_s next_r;

  logic [2:0] pin_level;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  // pins cross into mclk through three stages; bit 0 measure,
  // bit 1 oscillator output, bit 2 reference oscillator
  tec_pin_sync #(
    .W(3)
  ) u_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .din({low_speed_ref_osc, rf_osc_out, measure_input_pin}),
    .level(),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  function automatic tec_sel_e reg_sel(
    input logic [TEC_ADDR_W-1:0] a
  );
    case (a)
      TEC_OFF_A_LO: reg_sel = TEC_SEL_A_LO;
      TEC_OFF_A_HI: reg_sel = TEC_SEL_A_HI;
      TEC_OFF_B_LO: reg_sel = TEC_SEL_B_LO;
      TEC_OFF_B_HI: reg_sel = TEC_SEL_B_HI;
      TEC_OFF_CTRL: reg_sel = TEC_SEL_CTRL;
      TEC_OFF_CONV: reg_sel = TEC_SEL_CONV;
      TEC_OFF_STAT: reg_sel = TEC_SEL_STAT;
      default: reg_sel = TEC_SEL_NONE;
    endcase
  endfunction : reg_sel

  tec_sel_e wsel;
  tec_sel_e rsel;
  logic do_wr;
  logic rd_take;
  logic locked;
  logic hold;
  logic a_tick;
  logic b_tick;
  logic evt_edge;
  logic pw_start;
  logic pw_stop;
  logic ov_a;
  logic ov_b;

  always_comb begin
    next_r = r;
    wsel = reg_sel(r.aw_addr);
    rsel = reg_sel(s_axi_araddr);
    locked = r.conv && r.run;
    do_wr = r.aw_got && r.w_got && !r.bvalid;
    rd_take = s_axi_arvalid && r.arready;
    // with the converter off, a read of the A high byte stalls the count for that cycle
    hold = rd_take && rsel == TEC_SEL_A_HI && !r.conv; // [R5]
    evt_edge = r.edge_pol ? pin_fall[0] : pin_rise[0]; // [R8]
    pw_start = r.edge_pol ? pin_rise[0] : pin_fall[0]; // [R9]
    pw_stop = r.edge_pol ? pin_fall[0] : pin_rise[0]; // [R9]
    a_tick = 1'b0;
    b_tick = 1'b0;
    ov_a = 1'b0;
    ov_b = 1'b0;

    // write channels, taken in either order
    if (s_axi_awvalid && r.awready) begin
      next_r.aw_got = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      next_r.w_got = 1'b1;
      next_r.w_data = s_axi_wdata[7:0];
      next_r.w_lane0 = s_axi_wstrb[0];
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (do_wr) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = (wsel == TEC_SEL_NONE) ? TEC_RESP_SLVERR
                                            : TEC_RESP_OKAY;
      if (r.w_lane0) begin
        case (wsel)
          TEC_SEL_A_LO, TEC_SEL_B_LO: begin
            if (!locked) begin // [R16]
              next_r.lo_buf = r.w_data; // [R2] [R17]
            end
          end
          TEC_SEL_A_HI: begin
            // in counter mode A is the live count; it loads from B
            if (r.conv && !r.run) begin
              next_r.cnt_a = {r.w_data, r.lo_buf}; // [R17]
            end
          end
          TEC_SEL_B_HI: begin
            if (!locked) begin // [R16]
              next_r.cnt_b = {r.w_data, r.lo_buf}; // [R2] [R17]
              if (!r.conv && !r.run) begin
                next_r.cnt_a = {r.w_data, r.lo_buf}; // [R4]
              end
            end
          end
          TEC_SEL_CTRL: begin
            next_r.mode = r.w_data[TEC_CTRL_MODE_LSB +: 2]; // [R6]
            next_r.run = r.w_data[TEC_CTRL_RUN]; // [R11]
            next_r.edge_pol = r.w_data[TEC_CTRL_EDGE];
            next_r.pw_active = 1'b0;
          end
          TEC_SEL_CONV: begin
            next_r.bsel = r.w_data[TEC_CONV_BSEL]; // [R13]
            next_r.conv = r.w_data[TEC_CONV_EN]; // [R1] [R12]
            next_r.ovsel = r.w_data[TEC_CONV_OVSEL]; // [R14]
          end
          TEC_SEL_STAT: begin
            if (r.w_data[TEC_STAT_FLAG]) begin
              next_r.flag = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // read channel; arready is low while an answer stands
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (rd_take) begin
      next_r.rvalid = 1'b1;
      next_r.rdata = '0;
      next_r.rresp = TEC_RESP_OKAY;
      case (rsel)
        TEC_SEL_A_LO, TEC_SEL_B_LO: begin
          if (!locked) begin // [R16]
            next_r.rdata[7:0] = r.lo_buf; // [R3] [R18]
          end
        end
        TEC_SEL_A_HI: begin
          if (!locked) begin
            next_r.rdata[7:0] = r.cnt_a[15:8];
            next_r.lo_buf = r.cnt_a[7:0]; // [R3] [R18]
          end
        end
        TEC_SEL_B_HI: begin
          if (!locked) begin
            next_r.rdata[7:0] = r.cnt_b[15:8];
            next_r.lo_buf = r.cnt_b[7:0]; // [R18]
          end
        end
        TEC_SEL_CTRL: begin
          next_r.rdata[TEC_CTRL_MODE_LSB +: 2] = r.mode;
          next_r.rdata[TEC_CTRL_RUN] = r.run;
          next_r.rdata[TEC_CTRL_EDGE] = r.edge_pol;
        end
        TEC_SEL_CONV: begin
          next_r.rdata[TEC_CONV_BSEL] = r.bsel;
          next_r.rdata[TEC_CONV_EN] = r.conv;
          next_r.rdata[TEC_CONV_OVSEL] = r.ovsel;
        end
        TEC_SEL_STAT: begin
          next_r.rdata[TEC_STAT_FLAG] = r.flag;
        end
        default: begin
          next_r.rresp = TEC_RESP_SLVERR;
        end
      endcase
    end

    // counting runs after the bus so hardware set and clear win
    if (r.run && !r.conv) begin // [R11] [R1]
      case (r.mode)
        TEC_MODE_EVENT: a_tick = evt_edge; // [R6]
        TEC_MODE_TIMER: a_tick = 1'b1; // [R6]
        TEC_MODE_PULSE: begin
          // edges, not levels, start and stop; one pulse only
          if (!r.pw_active) begin
            next_r.pw_active = pw_start; // [R9] [R10]
          end else if (pw_stop) begin
            next_r.pw_active = 1'b0;
            next_r.run = 1'b0; // [R9] [R11]
          end else begin
            a_tick = 1'b1;
          end
        end
        default: a_tick = 1'b0;
      endcase
      if (a_tick && !hold) begin // [R5]
        if (r.cnt_a == CNT_MAX) begin
          next_r.cnt_a = r.cnt_b; // [R7] [R10]
          next_r.flag = 1'b1; // [R7]
        end else begin
          next_r.cnt_a = r.cnt_a + 1'b1; // [R7]
        end
      end
    end else if (r.run && r.conv) begin // [R12]
      a_tick = (r.mode == TEC_MODE_EVENT) ? evt_edge : 1'b1;
      b_tick = r.bsel ? pin_rise[1] : pin_rise[2]; // [R13]
      ov_a = a_tick && r.cnt_a == CNT_MAX;
      ov_b = b_tick && r.cnt_b == CNT_MAX;
      // plain wrap, no preset reload in this mode
      if (a_tick) begin
        next_r.cnt_a = r.cnt_a + 1'b1; // [R20]
      end
      if (b_tick) begin
        next_r.cnt_b = r.cnt_b + 1'b1; // [R20]
      end
      if (r.ovsel ? ov_b : ov_a) begin // [R14]
        next_r.flag = 1'b1; // [R15]
        next_r.run = 1'b0; // [R15] [R20]
      end
    end

    next_r.awready = !next_r.aw_got && !next_r.bvalid;
    next_r.wready = !next_r.w_got && !next_r.bvalid;
    next_r.arready = !next_r.rvalid;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
      r.cnt_a <= TEC_CNT_RST;
      r.cnt_b <= TEC_CNT_RST;
      r.mode <= TEC_CTRL_RST[TEC_CTRL_MODE_LSB +: 2];
      r.run <= TEC_CTRL_RST[TEC_CTRL_RUN];
      r.edge_pol <= TEC_CTRL_RST[TEC_CTRL_EDGE];
      r.bsel <= TEC_CONV_RST[TEC_CONV_BSEL];
      r.conv <= TEC_CONV_RST[TEC_CONV_EN];
      r.ovsel <= TEC_CONV_RST[TEC_CONV_OVSEL];
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bresp = r.bresp;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_arready = r.arready;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rvalid = r.rvalid;
  assign rc_timer_request_flag = r.flag;
endmodule : tec_timer

// ### sim/tb_tec_timer.sv
`timescale 1ns/1ps
`define CK(a, b) begin \
  comparisons++; \
  if ((a) !== (b)) begin \
    err_count++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); \
  end \
end
module tb_tec_timer;
  import tec_pkg::*;
  logic mclk = 1'h0;
  logic arst_n = 1'h0;
  logic ce = 1'h1;
  logic [4:0] s_axi_awaddr = 5'h00;
  logic [4:0] s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic pin_cmd = 1'h0;
  logic osc_en = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, rc_timer_request_flag;
  logic measure_input_pin, rf_osc_out, low_speed_ref_osc;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata;
  logic [7:0] d;
  int err_count = 0;
  int comparisons = 0;
  always #10 mclk = ~mclk;
  tec_timer tec_timer_inst (.mclk, .arst_n, .ce, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .measure_input_pin, .rf_osc_out, .low_speed_ref_osc,
    .rc_timer_request_flag);
  tec_pin_model tec_pin_model_inst (.pin_cmd, .osc_en, .measure_input_pin,
    .rf_osc_out, .low_speed_ref_osc);
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic hang(input bit t);
    if (t) begin
      err_count++;
      complete_run;
    end
  endtask : hang
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 99);
    hang(n >= 99);
    rs = s_axi_bresp;
    // late bready exercises the answer hold
    s_axi_bready <= 1'h1;
    @(posedge mclk);
    s_axi_bready <= 1'h0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [4:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 99);
    hang(n >= 99);
    s_axi_rready <= 1'h1;
    @(posedge mclk);
    d = s_axi_rdata[7:0];
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge mclk);
  endtask : rd
  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    rd(a);
    `CK(d, e)
  endtask : rc
  task automatic wait_flag;
    int n;
    n = 0;
    while (!rc_timer_request_flag && n < 400) begin
      @(posedge mclk);
      n++;
    end
    hang(n >= 400);
  endtask : wait_flag
  task automatic clr_flag;
    wr(TEC_OFF_STAT, 8'h01);
    `CK(rc_timer_request_flag, 1'h0)
  endtask : clr_flag
  task automatic ld(input logic [4:0] lo, input logic [15:0] v);
    wr(lo, v[7:0]);
    wr(lo + 5'h04, v[15:8]);
  endtask : ld
  initial begin
    repeat (5) @(posedge mclk);
    arst_n <= 1'h1;
    @(posedge mclk);
    rc(TEC_OFF_CTRL, TEC_CTRL_RST);
    rc(TEC_OFF_CONV, TEC_CONV_RST);
    rd(5'h1C);
    `CK(rs, TEC_RESP_SLVERR)
    wr(5'h1C, 8'h00);
    `CK(rs, TEC_RESP_SLVERR)
    wr(TEC_OFF_CONV, 8'h00);
    `CK(rs, TEC_RESP_OKAY)
    $display("reset test done");
    ld(TEC_OFF_B_LO, 16'h1234);
    wr(TEC_OFF_B_LO, 8'h56);
    rc(TEC_OFF_A_HI, 8'h12);
    rc(TEC_OFF_A_LO, 8'h34);
    rc(TEC_OFF_B_HI, 8'h12);
    $display("preload test done");
    ld(TEC_OFF_B_LO, 16'hFF00);
    wr(TEC_OFF_CTRL, 8'h58);
    wr(TEC_OFF_B_HI, 8'h80);
    wait_flag;
    wr(TEC_OFF_CTRL, 8'h08);
    rc(TEC_OFF_A_HI, 8'h80);
    clr_flag;
    $display("timer test done");
    for (int e = 0; e < 2; e++) begin
      pin_cmd <= 1'h0;
      ld(TEC_OFF_B_LO, 16'h0000);
      wr(TEC_OFF_CTRL, 8'h30 | 8'(e << 3));
      repeat (5) begin
        pin_cmd <= ~pin_cmd;
        repeat (8) @(posedge mclk);
      end
      wr(TEC_OFF_CTRL, 8'h08);
      rc(TEC_OFF_A_HI, 8'h00);
      rc(TEC_OFF_A_LO, 8'(3 - e));
    end
    $display("event test done");
    pin_cmd <= 1'h0;
    ld(TEC_OFF_B_LO, 16'h0000);
    wr(TEC_OFF_CTRL, 8'h78);
    repeat (2) begin
      pin_cmd <= 1'h1;
      repeat (20) @(posedge mclk);
      pin_cmd <= 1'h0;
      repeat (10) @(posedge mclk);
    end
    rc(TEC_OFF_CTRL, 8'h68);
    rc(TEC_OFF_A_HI, 8'h00);
    rd(TEC_OFF_A_LO);
    `CK(d > 8'h12 && d < 8'h16, 1'h1)
    $display("pulse test done");
    wr(TEC_OFF_CONV, 8'h02);
    ld(TEC_OFF_A_LO, 16'hFFF0);
    ld(TEC_OFF_B_LO, 16'h0000);
    rc(TEC_OFF_A_HI, 8'hFF);
    rc(TEC_OFF_A_LO, 8'hF0);
    wr(TEC_OFF_CTRL, 8'h58);
    rc(TEC_OFF_A_HI, 8'h00);
    wait_flag;
    rc(TEC_OFF_CTRL, 8'h48);
    rc(TEC_OFF_A_HI, 8'h00);
    rc(TEC_OFF_A_LO, 8'h00);
    rc(TEC_OFF_B_HI, 8'h00);
    clr_flag;
    wr(TEC_OFF_CONV, 8'h43);
    ld(TEC_OFF_B_LO, 16'hFFFE);
    ld(TEC_OFF_A_LO, 16'h0000);
    osc_en <= 1'h1;
    wr(TEC_OFF_CTRL, 8'h58);
    wait_flag;
    osc_en <= 1'h0;
    rc(TEC_OFF_B_HI, 8'h00);
    rc(TEC_OFF_B_LO, 8'h00);
    rc(TEC_OFF_A_HI, 8'h00);
    clr_flag;
    $display("converter test done");
    complete_run;
  end
endmodule : tb_tec_timer
bind tec_timer tec_timer_sva tec_timer_sva_inst (.mclk, .arst_n,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .rc_timer_request_flag);

// ### sim/tec_pin_model.sv
`timescale 1ns/1ps
module tec_pin_model (
  input wire logic pin_cmd,
  input wire logic osc_en,
  output logic measure_input_pin,
  output logic rf_osc_out,
  output logic low_speed_ref_osc
);
  assign measure_input_pin = pin_cmd;
  initial rf_osc_out = 1'h0;
  initial low_speed_ref_osc = 1'h0;
  // reference runs free, unrelated to mclk
  always #3906 low_speed_ref_osc = ~low_speed_ref_osc;
  // sensor oscillator parks low while disabled
  always #50 rf_osc_out = osc_en ? ~rf_osc_out : 1'h0;
endmodule : tec_pin_model

// ### sim/tec_timer_sva.sv
`timescale 1ns/1ps
module tec_timer_sva
  import tec_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [TEC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rc_timer_request_flag
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  property p_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr)
    else $error("write answer late");
  property p_rd;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd: assert property (p_rd)
    else $error("read answer late");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write answer dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read answer dropped");
  property p_byte;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_byte: assert property (p_byte)
    else $error("read data wider than a byte");
  property p_unmap;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > TEC_OFF_STAT
      |=> s_axi_rresp == TEC_RESP_SLVERR && s_axi_rdata == 32'h00000000;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not refused");
  // the sticky flag may fall only as a write answer rises
  property p_flag;
    $fell(rc_timer_request_flag) |-> $rose(s_axi_bvalid);
  endproperty
  a_flag: assert property (p_flag)
    else $error("flag cleared without a write");
  property p_rdy;
    $rose(arst_n) |-> s_axi_awready && s_axi_wready && s_axi_arready;
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("not ready after reset");
  c_flag: cover property ($rose(rc_timer_request_flag));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == TEC_RESP_SLVERR);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule : tec_timer_sva
